/* File: cue_chan_model.sv */
`timescale 1ns/1ps
// ------------------------------
// Channel side of the tag link
// ------------------------------
module cue_chan_model (
   input wire logic ref_clk_i, // Clock
   input wire logic rst_b_i, // Reset, low
   input wire logic sel_req_i, // Hold select out
   input wire logic amode_i, // Offer an address
   input wire logic [8:0] adr_i, // Address and parity
   input wire logic stop_i, // Answer service with stop
   input wire logic stack_i, // Stack offered status
   input wire logic adr_in_i, // Address in
   input wire logic sts_in_i, // Status in
   input wire logic svc_in_i, // Service in
   output logic sel_out_o, // Select out
   output logic adr_out_o, // Address out
   output logic cmd_out_o, // Command out
   output logic svc_out_o, // Service out
   output logic [8:0] bus_out_o // Bus out
);
   // Interlocked answers, raised and dropped after each inbound tag
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sel_out_o <= 1'b0;
         adr_out_o <= 1'b0;
         cmd_out_o <= 1'b0;
         svc_out_o <= 1'b0;
         bus_out_o <= 9'h000;
      end
      else
      begin
         sel_out_o <= sel_req_i;
         adr_out_o <= amode_i;
         cmd_out_o <= adr_in_i | (sts_in_i & stack_i) | (svc_in_i & stop_i);
         svc_out_o <= (sts_in_i & ~stack_i) | (svc_in_i & ~stop_i);
         bus_out_o <= amode_i ? adr_i : ~bus_out_o; // Released bus toggles
      end
   end
endmodule

/* File: cue_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - On stop drop service-in, finish the device operation, request no more data.
// - At the channel-end point put ending status on bus-in and raise status-in.
// - When connected with status ready, present ending status at once.
// - When disconnected, reconnect by a unit-initiated sequence, then present status.
// - Channel end and device end go together when both exist, else separately.
// - Device end left behind is presented later by a unit-initiated sequence.
// - Single-activity unit serves one device from first command to chaining reset.
// - Sense data held from unit-check acceptance until a non-test non-nop command.
// - Single-activity chaining: the channel-end device presents the next device end.
// - Multi-activity unit runs devices concurrently, answering busy to limit activity.
// - Hybrid unit delays other devices while unit-check sense data is pending.
// - Devices are addressed by one byte with parity, unique on the interface.
// - Address set is contiguous, sized min(devices,16), aligned on its size.
// - Beyond sixteen devices add sets of sixteen, never fifteen spare addresses.
// - A lone device may use any byte address not claimed elsewhere.
// - Recognize an address only with good parity and inside the assigned set.
// - Ignore addresses outside the set, including unused low device numbers.
// - Unrecognized address passes select-out down the chain toward select-in.
// - Device portion of the address is the same on every path.
// - Raise request-in, then on select-out without address-out give address and operational.
// - Addressing an uninstalled device sets unit check and sense data.
module cue_ctrl (
   input wire logic ref_clk_i, // Clock, 40 MHz
   input wire logic rst_b_i, // Async reset, low
   input wire logic ce_i, // Clock enable
   input wire logic [3:0] avs_address_i, // Byte address
   input wire logic avs_read_i, // Read request
   input wire logic avs_write_i, // Write request
   input wire logic [31:0] avs_writedata_i, // Write data
   input wire logic [3:0] avs_byteenable_i, // Byte lanes
   output logic [31:0] avs_readdata_o, // Read data
   output logic avs_waitrequest_o, // Wait request
   input wire logic sel_out_i, // Select out pin
   input wire logic adr_out_i, // Address out pin
   input wire logic cmd_out_i, // Command out pin
   input wire logic svc_out_i, // Service out pin
   input wire logic [8:0] bus_out_i, // Bus out, bit 8 parity
   output logic sel_in_o, // Propagated select
   output logic op_in_o, // Operational in
   output logic adr_in_o, // Address in
   output logic sts_in_o, // Status in
   output logic svc_in_o, // Service in
   output logic req_in_o, // Request in
   output logic [8:0] bus_in_o, // Bus in, bit 8 parity
   input wire logic ev_ce_i, // Device at channel end
   input wire logic ev_de_i, // Device at device end
   input wire logic ev_uc_i, // Unit check with event
   input wire logic [3:0] ev_dev_i, // Event device
   input wire logic data_req_i, // Device wants data service
   input wire logic [7:0] data_i, // Data byte for bus in
   input wire logic cmd_acc_i, // Command accepted
   input wire logic [3:0] cmd_dev_i, // Command device
   input wire logic cmd_tio_nop_i, // Command is test or no-op
   input wire logic cmd_chain_i, // Chaining indicated
   input wire logic chain_rst_i, // Chaining condition reset
   output logic dev_stop_o, // Stop received
   output logic sel_hit_o, // Address recognized
   output logic [3:0] sel_dev_o, // Recognized device
   output logic nodev_o // Uninstalled device hit
);

   typedef struct packed {
      logic [3:0] t1;
      logic [3:0] t2;
      logic [8:0] b1;
      logic [8:0] b2;
      logic sel_q;
      cue_pkg::cue_st_t st;
      logic [31:0] cfg;
      logic [31:0] inst;
      logic [31:0] rdata;
      logic wreq;
      logic sel_in;
      logic op;
      logic adr_in;
      logic sts_in;
      logic svc_in;
      logic req_in;
      logic [8:0] bus_in;
      logic [7:0] addr;
      logic [7:0] sbyte;
      logic stop;
      logic ce_p;
      logic [3:0] ce_dev;
      logic [15:0] dep;
      logic [15:0] uc_p;
      logic [3:0] cur;
      logic pres_ce;
      logic pres_de;
      logic act;
      logic [3:0] act_dev;
      logic chain;
      logic sense;
      logic [3:0] sense_dev;
      logic cpri;
      logic [3:0] cdev;
      logic hit;
      logic [3:0] hdev;
      logic nodev;
   } cue_state_t;

   cue_state_t r;
   cue_state_t n;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic [8:0] cnt_w;
   logic [7:0] mask_w;
   logic [7:0] base_w;
   logic [7:0] adr_w;
   logic [8:0] off_w;
   logic par_ok_w;
   logic hit_w;
   logic inst_w;
   logic [3:0] dev_w;
   logic sel_rise_w;
   logic busy_w;
   logic pend_w;
   logic ready_w;
   logic [3:0] pick_w;
   logic [31:0] rd_w;
   cue_pkg::cue_type_t type_w;

   // Low mask of the set size, capped at sixteen
   always_comb
   begin
      mask_w = 8'h00;
      for (int i = 0; i < 4; i++)
      begin
         if (cnt_w > (9'h001 << i))
         begin
            mask_w[i] = 1'b1;
         end
      end
   end

   // Set base and offset of the presented address
   assign cnt_w = r.cfg[cue_pkg::CFG_CNT +: 9];
   assign base_w = r.cfg[cue_pkg::CFG_BASE +: 8] & ~mask_w;
   assign adr_w = r.b2[7:0];
   assign off_w = {1'b0, adr_w} - {1'b0, base_w};
   assign par_ok_w = ((^r.b2) == cue_pkg::PAR_ODD);
   assign hit_w = par_ok_w && (adr_w >= base_w) && (off_w < cnt_w);
   assign dev_w = off_w[3:0];
   assign inst_w = (off_w < cue_pkg::SET_MAX) ? r.inst[dev_w] : 1'b1;
   assign sel_rise_w = r.t2[cue_pkg::TG_SEL] & ~r.sel_q;
   assign type_w = cue_pkg::cue_type_t'(r.cfg[cue_pkg::CFG_TYPE +: 2]);

   // Concurrency policy for an attempted selection
   always_comb
   begin
      case (type_w)
         cue_pkg::CUT_SINGLE:
            busy_w = (r.act && r.act_dev != dev_w) || (r.sense && r.sense_dev != dev_w);
         cue_pkg::CUT_HYBRID:
            busy_w = r.cfg[cue_pkg::CFG_LIM] || (r.sense && r.sense_dev != dev_w);
         default:
            busy_w = r.cfg[cue_pkg::CFG_LIM];
      endcase
   end

   // Device whose status goes out next
   always_comb
   begin
      pick_w = 4'h0;
      for (int i = 15; i >= 0; i--)
      begin
         if (r.dep[i])
         begin
            pick_w = 4'(i);
         end
      end
      if (r.cpri && r.dep[r.cdev])
      begin
         pick_w = r.cdev;
      end
      if (r.ce_p)
      begin
         pick_w = r.ce_dev;
      end
   end

   assign pend_w = r.ce_p | (|r.dep);
   assign ready_w = (r.ce_p && r.ce_dev == r.cur) || r.dep[r.cur];

   // Register read mux
   always_comb
   begin
      case (avs_address_i)
         cue_pkg::REG_CFG: rd_w = r.cfg;
         cue_pkg::REG_INST: rd_w = r.inst;
         cue_pkg::REG_STAT: rd_w = {15'h0000, r.ce_p, r.act_dev, r.sense_dev, r.stop, r.chain, r.act, r.sense, r.st};
         cue_pkg::REG_DEP: rd_w = {16'h0000, r.dep};
         default: rd_w = 32'h0000_0000;
      endcase
   end

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      n = r;
      n.t1 = {svc_out_i, cmd_out_i, adr_out_i, sel_out_i};
      n.t2 = r.t1;
      n.b1 = bus_out_i;
      n.b2 = r.b1;
      n.sel_q = r.t2[cue_pkg::TG_SEL];
      n.hit = 1'b0;
      n.nodev = 1'b0;

      // Bus slave, one wait cycle per access
      n.wreq = 1'b1;
      if ((avs_read_i | avs_write_i) && r.wreq)
      begin
         n.wreq = 1'b0;
         n.rdata = rd_w;
      end
      if (avs_write_i && !r.wreq)
      begin
         if (avs_address_i == cue_pkg::REG_CFG)
         begin
            n.cfg = merge(r.cfg, avs_writedata_i, avs_byteenable_i);
         end
         if (avs_address_i == cue_pkg::REG_INST)
         begin
            n.inst = merge(r.inst, avs_writedata_i, avs_byteenable_i);
         end
      end

      // Activity and sense-hold clears
      if (chain_rst_i)
      begin
         n.act = 1'b0;
         n.chain = 1'b0;
      end
      if (cmd_acc_i)
      begin
         n.act = 1'b1;
         n.act_dev = cmd_dev_i;
         n.chain = cmd_chain_i;
         if (r.sense && cmd_dev_i == r.sense_dev && !cmd_tio_nop_i)
         begin
            n.sense = 1'b0;
         end
      end

      // Tag sequencer
      case (r.st)
         cue_pkg::ST_IDLE:
            if (sel_rise_w && r.t2[cue_pkg::TG_ADR] && hit_w)
            begin
               n.hit = 1'b1;
               n.hdev = dev_w;
               n.cpri = 1'b0;
               n.addr = adr_w;
               n.cur = dev_w;
               if (!inst_w)
               begin
                  n.nodev = 1'b1;
                  n.uc_p[dev_w] = 1'b1;
               end
               n.st = busy_w ? cue_pkg::ST_SBUSY : cue_pkg::ST_ADDR;
               n.sbyte = 8'h00;
               n.sbyte[cue_pkg::SB_BUSY] = 1'b1;
            end
            else if (sel_rise_w && !r.t2[cue_pkg::TG_ADR] && pend_w)
            begin
               n.st = cue_pkg::ST_ADDR;
               n.cur = pick_w;
               n.addr = base_w + {4'h0, pick_w};
            end
         cue_pkg::ST_SBUSY:
            if (!r.t2[cue_pkg::TG_SEL])
            begin
               n.st = cue_pkg::ST_IDLE;
            end
         cue_pkg::ST_ADDR:
            if (r.t2[cue_pkg::TG_CMD])
            begin
               n.st = cue_pkg::ST_PROC;
            end
         cue_pkg::ST_PROC:
            if (!r.t2[cue_pkg::TG_CMD])
            begin
               n.st = cue_pkg::ST_CONN;
            end
         cue_pkg::ST_CONN:
            if (ready_w)
            begin
               n.st = cue_pkg::ST_STAT;
               n.pres_ce = r.ce_p && r.ce_dev == r.cur;
               n.pres_de = r.dep[r.cur];
               n.sbyte = 8'h00;
               n.sbyte[cue_pkg::SB_CE] = r.ce_p && r.ce_dev == r.cur;
               n.sbyte[cue_pkg::SB_DE] = r.dep[r.cur];
               n.sbyte[cue_pkg::SB_UC] = r.uc_p[r.cur];
            end
            else if (data_req_i && !r.stop)
            begin
               n.st = cue_pkg::ST_SVC;
            end
            else if (!r.t2[cue_pkg::TG_SEL])
            begin
               n.st = cue_pkg::ST_IDLE;
            end
         cue_pkg::ST_SVC:
            if (r.t2[cue_pkg::TG_SVC])
            begin
               n.st = cue_pkg::ST_SVEND;
            end
            else if (r.t2[cue_pkg::TG_CMD])
            begin
               n.stop = 1'b1;
               n.st = cue_pkg::ST_SVEND;
            end
         cue_pkg::ST_STAT:
            if (r.t2[cue_pkg::TG_SVC])
            begin
               n.st = cue_pkg::ST_STEND;
               n.uc_p[r.cur] = 1'b0;
               if (r.sbyte[cue_pkg::SB_UC])
               begin
                  n.sense = 1'b1;
                  n.sense_dev = r.cur;
               end
               if (r.pres_ce)
               begin
                  n.ce_p = 1'b0;
                  n.stop = 1'b0;
                  if (!r.pres_de && r.chain && type_w == cue_pkg::CUT_SINGLE)
                  begin
                     n.cpri = 1'b1;
                     n.cdev = r.cur;
                  end
               end
               if (r.pres_de)
               begin
                  n.dep[r.cur] = 1'b0;
                  if (r.cdev == r.cur)
                  begin
                     n.cpri = 1'b0;
                  end
               end
            end
            else if (r.t2[cue_pkg::TG_CMD])
            begin
               n.st = cue_pkg::ST_STEND;
            end
         cue_pkg::ST_SVEND, cue_pkg::ST_STEND:
            if (!r.t2[cue_pkg::TG_SVC] && !r.t2[cue_pkg::TG_CMD])
            begin
               n.st = cue_pkg::ST_CONN;
            end
         default:
            n.st = cue_pkg::ST_IDLE;
      endcase

      // Device events, set wins over clear
      if (ev_ce_i)
      begin
         n.ce_p = 1'b1;
         n.ce_dev = ev_dev_i;
      end
      if (ev_de_i)
      begin
         n.dep[ev_dev_i] = 1'b1;
      end
      if (ev_uc_i)
      begin
         n.uc_p[ev_dev_i] = 1'b1;
      end

      // Outbound tags from next state
      n.op = (n.st != cue_pkg::ST_IDLE) && (n.st != cue_pkg::ST_SBUSY);
      n.adr_in = (n.st == cue_pkg::ST_ADDR);
      n.sts_in = (n.st == cue_pkg::ST_STAT) || (n.st == cue_pkg::ST_SBUSY);
      n.svc_in = (n.st == cue_pkg::ST_SVC);
      n.req_in = (n.st == cue_pkg::ST_IDLE) && pend_w;
      n.sel_in = r.t2[cue_pkg::TG_SEL] && (n.st == cue_pkg::ST_IDLE);
      n.bus_in = 9'h000;
      if (n.st == cue_pkg::ST_ADDR)
      begin
         n.bus_in = {(^n.addr) ^ cue_pkg::PAR_ODD, n.addr};
      end
      else if (n.sts_in)
      begin
         n.bus_in = {(^n.sbyte) ^ cue_pkg::PAR_ODD, n.sbyte};
      end
      else if (n.svc_in)
      begin
         n.bus_in = {(^data_i) ^ cue_pkg::PAR_ODD, data_i};
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         r <= '0;
         r.st <= cue_pkg::ST_IDLE;
         r.cfg <= cue_pkg::CFG_RST;
         r.inst <= cue_pkg::INST_RST;
         r.wreq <= 1'b1;
      end
      else if (ce_i)
      begin
         r <= n;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_o = r.rdata;
   assign avs_waitrequest_o = r.wreq;
   assign sel_in_o = r.sel_in;
   assign op_in_o = r.op;
   assign adr_in_o = r.adr_in;
   assign sts_in_o = r.sts_in;
   assign svc_in_o = r.svc_in;
   assign req_in_o = r.req_in;
   assign bus_in_o = r.bus_in;
   assign dev_stop_o = r.stop;
   assign sel_hit_o = r.hit;
   assign sel_dev_o = r.hdev;
   assign nodev_o = r.nodev;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_stop_seen;
      ce_i && r.st == cue_pkg::ST_SVC && !r.t2[cue_pkg::TG_SVC] && r.t2[cue_pkg::TG_CMD];
   endsequence
   sequence s_stat_taken;
      ce_i && r.st == cue_pkg::ST_STAT && r.t2[cue_pkg::TG_SVC];
   endsequence

   a_stop_drops_svc: assert property (s_stop_seen |=> !r.svc_in && r.stop)
      else $error("service in not dropped on stop");
   a_no_svc_stopped: assert property ($rose(r.svc_in) |-> !$past(r.stop))
      else $error("data service requested after stop");
   a_status_now: assert property (ce_i && r.st == cue_pkg::ST_CONN && ready_w |=> r.sts_in && r.op)
      else $error("ready status not presented");
   a_reconnect_first: assert property ($rose(r.sts_in) && r.op |-> $past(r.op))
      else $error("status presented without connection");
   a_both_cleared: assert property (s_stat_taken ##0 r.pres_ce && r.pres_de && !ev_de_i |=> !r.dep[$past(r.cur)])
      else $error("device end kept after joint ending");
   a_request_de: assert property (ce_i && r.st == cue_pkg::ST_IDLE && (|r.dep) ##1 r.st == cue_pkg::ST_IDLE |-> r.req_in)
      else $error("device end without request in");
   a_single_busy: assert property (ce_i && r.st == cue_pkg::ST_IDLE && sel_rise_w && r.t2[cue_pkg::TG_ADR] && hit_w
      && type_w == cue_pkg::CUT_SINGLE && r.act && r.act_dev != dev_w |=> r.st == cue_pkg::ST_SBUSY)
      else $error("second device started on single unit");
   a_sense_held: assert property (s_stat_taken ##0 r.sbyte[cue_pkg::SB_UC] |=> r.sense)
      else $error("sense hold not set on unit check");
   a_bad_parity: assert property (ce_i && r.st == cue_pkg::ST_IDLE && sel_rise_w && r.t2[cue_pkg::TG_ADR] && !par_ok_w
      |=> r.st == cue_pkg::ST_IDLE && !r.hit)
      else $error("address with bad parity recognized");
   a_sel_passed: assert property (ce_i && r.st == cue_pkg::ST_IDLE && sel_rise_w && r.t2[cue_pkg::TG_ADR] && !hit_w
      |=> r.sel_in)
      else $error("unrecognized select not propagated");
endmodule

/* File: cue_pkg.sv */
package cue_pkg;
   // ----------------------------------------
   // Register map and reset values
   // ----------------------------------------
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_INST = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_DEP = 4'hc;
   localparam logic [31:0] CFG_RST = 32'h0002_0100;
   localparam logic [31:0] INST_RST = 32'h0000_ffff;
   localparam int CFG_BASE = 0;
   localparam int CFG_CNT = 8;
   localparam int CFG_TYPE = 17;
   localparam int CFG_LIM = 19;

   // ----------------------------------------
   // Channel tags, bus and status byte
   // ----------------------------------------
   localparam int TG_SEL = 0;
   localparam int TG_ADR = 1;
   localparam int TG_CMD = 2;
   localparam int TG_SVC = 3;
   localparam int SB_BUSY = 3;
   localparam int SB_CE = 4;
   localparam int SB_DE = 5;
   localparam int SB_UC = 6;
   localparam logic PAR_ODD = 1'b1;
   localparam logic [8:0] SET_MAX = 9'h010;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      CUT_SINGLE = 2'h0,
      CUT_MULTI = 2'h1,
      CUT_HYBRID = 2'h2
   } cue_type_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_PROC = 4'h2,
      ST_CONN = 4'h3,
      ST_SVC = 4'h4,
      ST_SVEND = 4'h5,
      ST_STAT = 4'h6,
      ST_STEND = 4'h7,
      ST_SBUSY = 4'h8
   } cue_st_t;
endpackage

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, d;
   logic avs_waitrequest_o, sel_out, adr_out, cmd_out, svc_out;
   logic [8:0] bus_out, bus_in_o, ch_adr = 9'h000;
   logic [8:0] refused [4];
   logic sel_in_o, op_in_o, adr_in_o, sts_in_o, svc_in_o, req_in_o, dev_stop_o, sel_hit_o, nodev_o;
   logic ev_ce_i = 1'b0, ev_de_i = 1'b0, ev_uc_i = 1'b0, data_req_i = 1'b0, cmd_acc_i = 1'b0;
   logic [3:0] ev_dev_i = 4'h0, cmd_dev_i = 4'h0, sel_dev_o, hit_dev = 4'h0;
   logic ch_sel = 1'b0, ch_amode = 1'b0, ch_stop = 1'b0, ch_stack = 1'b0;
   logic ce_en = 1'b1;
   logic [31:0] busy_cfg [3];
   int miscompares = 0, cmp_count = 0, cyc = 0, hit_n = 0, nodev_n = 0;
   wire logic [5:0] tags = {req_in_o, svc_in_o, sts_in_o, adr_in_o, op_in_o, sel_in_o};

   always #12.5 ref_clk_i = ~ref_clk_i;

   cue_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_en), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .sel_out_i(sel_out), .adr_out_i(adr_out), .cmd_out_i(cmd_out), .svc_out_i(svc_out), .bus_out_i(bus_out),
      .sel_in_o(sel_in_o), .op_in_o(op_in_o), .adr_in_o(adr_in_o), .sts_in_o(sts_in_o), .svc_in_o(svc_in_o),
      .req_in_o(req_in_o), .bus_in_o(bus_in_o), .ev_ce_i(ev_ce_i), .ev_de_i(ev_de_i), .ev_uc_i(ev_uc_i),
      .ev_dev_i(ev_dev_i), .data_req_i(data_req_i), .data_i(8'h5a), .cmd_acc_i(cmd_acc_i),
      .cmd_dev_i(cmd_dev_i), .cmd_tio_nop_i(1'b0), .cmd_chain_i(1'b0), .chain_rst_i(1'b0),
      .dev_stop_o(dev_stop_o), .sel_hit_o(sel_hit_o), .sel_dev_o(sel_dev_o), .nodev_o(nodev_o));

   cue_chan_model u_chan (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sel_req_i(ch_sel), .amode_i(ch_amode),
      .adr_i(ch_adr), .stop_i(ch_stop), .stack_i(ch_stack), .adr_in_i(adr_in_o), .sts_in_i(sts_in_o),
      .svc_in_i(svc_in_o), .sel_out_o(sel_out), .adr_out_o(adr_out), .cmd_out_o(cmd_out),
      .svc_out_o(svc_out), .bus_out_o(bus_out));

   // ------------------------------
   // Helpers
   // ------------------------------
   function automatic logic [8:0] par9(input logic [7:0] b);
      return {~^b, b};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One register access, held until waitrequest is seen low
   task automatic bus_acc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do
      begin
         @(posedge ref_clk_i);
      end
      while (avs_waitrequest_o !== 1'b0);
      d = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic wait_tag(input int t, input logic v, input string what);
      int n = 0;
      while (tags[t] !== v && n < 60)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      chk(what, {31'h0, v}, {31'h0, tags[t]});
   endtask

   task automatic select_adr(input logic [8:0] a);
      ch_adr <= a;
      ch_amode <= 1'b1;
      @(posedge ref_clk_i);
      ch_sel <= 1'b1;
   endtask

   task automatic drop_sel();
      ch_amode <= 1'b0;
      ch_sel <= 1'b0;
      wait_tag(1, 1'b0, "operational in drop");
      wait_tag(0, 1'b0, "select in drop");
      repeat (4) @(posedge ref_clk_i);
   endtask

   // Pulse capture and run ceiling
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (sel_hit_o === 1'b1)
      begin
         hit_n <= hit_n + 1;
         hit_dev <= sel_dev_o;
      end
      if (nodev_o === 1'b1)
         nodev_n <= nodev_n + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      refused = '{par9(8'h4a), par9(8'h4f), par9(8'h3f), par9(8'h43) ^ 9'h100};
      busy_cfg = '{32'h0000_0a40, 32'h0004_0a40, 32'h000a_0a40};
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      chk("tags after reset", 0, tags);
      bus_acc(1'b0, cue_pkg::REG_CFG, 0);
      chk("cfg reset", cue_pkg::CFG_RST, d);
      bus_acc(1'b0, cue_pkg::REG_INST, 0);
      chk("inst reset", cue_pkg::INST_RST, d);
      bus_acc(1'b1, 4'h2, 32'hffff_ffff);
      bus_acc(1'b0, 4'h2, 0);
      chk("unmapped read", 0, d);
      bus_acc(1'b1, cue_pkg::REG_CFG, 32'h0002_0a40);
      bus_acc(1'b1, cue_pkg::REG_INST, 32'h0000_ff7f);
      bus_acc(1'b0, cue_pkg::REG_CFG, 0);
      chk("cfg written", 32'h0002_0a40, d);
      // Addresses beyond the set, below it, or with bad parity pass on
      foreach (refused[i])
      begin
         select_adr(refused[i]);
         wait_tag(0, 1'b1, "select passed");
         drop_sel();
      end
      chk("no hit when refused", 0, hit_n);
      // Last device of the set, then a stopped transfer
      select_adr(par9(8'h49));
      wait_tag(2, 1'b1, "address in");
      chk("address echoed", par9(8'h49), bus_in_o);
      ch_amode <= 1'b0;
      wait_tag(2, 1'b0, "proceed taken");
      chk("device index", 9, hit_dev);
      cmd_dev_i <= 4'h9;
      cmd_acc_i <= 1'b1;
      @(posedge ref_clk_i);
      cmd_acc_i <= 1'b0;
      ch_stop <= 1'b1;
      data_req_i <= 1'b1;
      wait_tag(4, 1'b1, "service in");
      chk("data on bus in", par9(8'h5a), bus_in_o);
      wait_tag(4, 1'b0, "stop taken");
      repeat (12) @(posedge ref_clk_i);
      chk("no service after stop", 0, svc_in_o);
      chk("stop flag", 1, dev_stop_o);
      data_req_i <= 1'b0;
      ev_dev_i <= 4'h9;
      ev_ce_i <= 1'b1;
      ev_de_i <= 1'b1;
      @(posedge ref_clk_i);
      ev_ce_i <= 1'b0;
      ev_de_i <= 1'b0;
      wait_tag(3, 1'b1, "ending status");
      chk("joint ending byte", par9(8'h01 << cue_pkg::SB_CE | 8'h01 << cue_pkg::SB_DE), bus_in_o);
      wait_tag(3, 1'b0, "status accepted");
      repeat (4) @(posedge ref_clk_i);
      chk("stop cleared", 0, dev_stop_o);
      ch_stop <= 1'b0;
      drop_sel();
      // Device end alone while disconnected: reconnect, stack, retry
      ev_dev_i <= 4'h5;
      ev_de_i <= 1'b1;
      @(posedge ref_clk_i);
      ev_de_i <= 1'b0;
      wait_tag(5, 1'b1, "request in");
      ch_stack <= 1'b1;
      ch_sel <= 1'b1;
      wait_tag(2, 1'b1, "reconnect address");
      chk("reconnect device", par9(8'h45), bus_in_o);
      wait_tag(3, 1'b1, "status offered");
      chk("device end byte", par9(8'h01 << cue_pkg::SB_DE), bus_in_o);
      wait_tag(3, 1'b0, "status stacked");
      ch_stack <= 1'b0;
      wait_tag(3, 1'b1, "status again");
      chk("device end again", par9(8'h01 << cue_pkg::SB_DE), bus_in_o);
      wait_tag(3, 1'b0, "status accepted");
      drop_sel();
      chk("request dropped", 0, req_in_o);
      // Address inside the set without an installed device
      select_adr(par9(8'h47));
      wait_tag(2, 1'b1, "uninstalled hit");
      ch_amode <= 1'b0;
      wait_tag(2, 1'b0, "proceed taken");
      chk("no device flag", 1, nodev_n);
      ev_dev_i <= 4'h7;
      ev_ce_i <= 1'b1;
      @(posedge ref_clk_i);
      ev_ce_i <= 1'b0;
      wait_tag(3, 1'b1, "unit check status");
      chk("unit check byte", par9(8'h01 << cue_pkg::SB_CE | 8'h01 << cue_pkg::SB_UC), bus_in_o);
      wait_tag(3, 1'b0, "unit check accepted");
      drop_sel();
      // Single, hybrid and limited multi units refuse another device
      foreach (busy_cfg[i])
      begin
         bus_acc(1'b1, cue_pkg::REG_CFG, busy_cfg[i]);
         select_adr(par9(8'h41));
         wait_tag(3, 1'b1, "busy status");
         chk("busy byte", par9(8'h01 << cue_pkg::SB_BUSY), bus_in_o);
         chk("no operational in", 0, op_in_o);
         drop_sel();
      end
      // Events are ignored while the clock enable is low
      ce_en <= 1'b0;
      ev_dev_i <= 4'h3;
      ev_de_i <= 1'b1;
      @(posedge ref_clk_i);
      ev_de_i <= 1'b0;
      ce_en <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      chk("frozen event dropped", 0, req_in_o);
      report_and_stop();
   end
endmodule
